// File: common/ldm_pkg.sv
// ldm_pkg: shared constants for the dot-matrix lcd driver
package ldm_pkg;
   // ****************************************
   // geometry
   // ****************************************
   localparam int NUM_COM = 16;
   localparam int NUM_SEG = 40;
   localparam int NUM_COM_EIGHTH = 8;
   localparam int NIB_W = 4;
   localparam int RAM_AW = 8;
   localparam int IDX_W = 12;
   localparam int HADDR_W = 14;
   // ****************************************
   // register indices (byte address = 4 * index)
   // ****************************************
   localparam logic [11:0] LCD_DISPLAY_CONTROL_IDX = 12'hf71;
   localparam logic [11:0] LCD_CONTRAST_LEVEL_IDX = 12'hf72;
   localparam logic [11:0] LCD_SCAN_STATUS_IDX = 12'hf73;
   localparam logic [11:0] LCD_VOLTAGE_ENABLE_IDX = 12'hf7f;
   // display memory: e00..e4f and e80..ecf
   localparam logic [3:0] DISP_IDX_HI = 4'he;
   localparam logic [6:0] DISP_LAST_OFS = 7'h4f;
   // ****************************************
   // field positions
   // ****************************************
   localparam int HEAVY_LOAD_PROTECT_BIT = 0;
   localparam int DUTY_SELECT_BIT = 1;
   localparam int ALL_DOTS_LIT_BIT = 2;
   localparam int ALL_DOTS_BLANK_BIT = 3;
   localparam int DRIVE_VOLTAGE_ENABLE_BIT = 0;
   localparam int STATUS_BUSY_BIT = 4;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [3:0] DISPLAY_CONTROL_RESET = 4'h8;
   localparam logic [3:0] CONTRAST_RESET = 4'h0;
   localparam logic DRIVE_VOLTAGE_RESET = 1'b1;
   // ****************************************
   // timing: frame = low_osc_frequency / 1024
   // ****************************************
   localparam int FRAME_DIV = 1024;
   localparam int FRAME_DIV_W = 10;
   localparam int COM_TICKS_SIXTEENTH = FRAME_DIV / NUM_COM;
   localparam int COM_TICKS_EIGHTH = FRAME_DIV / NUM_COM_EIGHTH;
   // ****************************************
   // scan fetch states
   // ****************************************
   typedef enum logic [1:0] {
      SC_IDLE,
      SC_READ,
      SC_DRAIN,
      SC_APPLY
   } ldm_scan_state_type;
endpackage

// File: hw/ldm_disp_ram.sv
// ldm_disp_ram: display memory, bus port and scan read port
`timescale 1ns/1ps
module ldm_disp_ram #(
   parameter int AW = 8,
   parameter int DW = 4
) (
   input wire logic i_ref_clk,
   input wire logic i_a_we,
   input wire logic [AW-1:0] i_a_waddr,
   input wire logic [DW-1:0] i_a_wdata,
   input wire logic i_a_re,
   input wire logic [AW-1:0] i_a_raddr,
   output logic [DW-1:0] o_a_rdata,
   input wire logic i_b_re,
   input wire logic [AW-1:0] i_b_raddr,
   output logic [DW-1:0] o_b_rdata
);
   // no reset: contents stay undefined until software fills them
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // bus write port
   always_ff @(posedge i_ref_clk) begin
      if (i_a_we) begin
         mem[i_a_waddr] <= i_a_wdata;
      end
   end

   // registered bus read
   always_ff @(posedge i_ref_clk) begin
      if (i_a_re) begin
         o_a_rdata <= mem[i_a_raddr];
      end
   end

   // registered scan read
   always_ff @(posedge i_ref_clk) begin
      if (i_b_re) begin
         o_b_rdata <= mem[i_b_raddr];
      end
   end
endmodule

// File: hw/ldm_lcd_driver.sv
// ldm_lcd_driver: dot-matrix lcd scan logic with ahb-lite registers
//
// Contract
// RQ1: drive 16 common and 40 segment lines, 640 dots in all.
// RQ2: software picks 1/16 or 1/8 multiplex duty.
// RQ3: 1/16 scans commons 0..15, 1/8 scans only commons 0..7.
// RQ4: segment data comes from display memory e00..e4f and e80..ecf.
// RQ5: a one bit lights its dot, a zero bit leaves it dark.
// RQ6: software must fill all display memory after reset.
// RQ7: duty_select one means 1/8, zero means 1/16, readable, resets 0.
// RQ8: all_dots_lit lights every dot, beats blank, resets 0.
// RQ9: all_dots_blank darkens every dot, memory untouched, resets 1.
// RQ10: readable 4-bit contrast code, 0 lightest to 15 darkest.
// RQ11: software loads contrast after reset, 7 or 8 typical.
// RQ12: drive_voltage_enable 0 grounds all drives, resets 1.
// RQ13: heavy_load_protect is bit 0 of display control, resets 0.
// RQ14: with external drive power the contrast code has no effect.
// RQ15: frame is low_osc_frequency/1024, commons stepped evenly.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module ldm_lcd_driver
   import ldm_pkg::*;
#(
   parameter int N_COM = NUM_COM,
   parameter int N_SEG = NUM_SEG
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [HADDR_W-1:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   // timing and power straps
   input wire logic i_low_osc,
   input wire logic i_ext_lcd_power,
   // panel side
   output logic [N_COM-1:0] o_common_lines,
   output logic [N_SEG-1:0] o_segment_lines,
   output logic [3:0] o_contrast_code,
   output logic o_voltage_circuit_on,
   output logic o_heavy_load_protect
);
   // ****************************************
   // elaboration checks
   // ****************************************
   if (N_COM != NUM_COM || N_SEG != NUM_SEG) begin : g_chk
      $error("ldm_lcd_driver: only 16 commons and 40 segments served");
   end

   // ****************************************
   // declarations
   // ****************************************
   logic accept;
   logic dph_valid_q;
   logic dph_write_q;
   logic [IDX_W-1:0] dph_idx_q;
   logic rd_done_q;
   logic rd_issue;
   logic wr_commit;
   logic dph_is_disp;
   logic [RAM_AW-1:0] dph_ram_addr;
   logic sel_mem_q;
   logic [31:0] reg_rdata_q;
   logic [31:0] rd_mux;
   logic [3:0] ctrl_q;
   logic [3:0] contrast_q;
   logic dve_q;
   logic [NIB_W-1:0] a_rdata;
   logic [NIB_W-1:0] b_rdata;
   logic step;
   logic [3:0] tmr_com_idx;
   logic start_q;
   ldm_scan_state_type state_q;
   logic [3:0] fetch_com_q;
   logic [5:0] seg_cnt_q;
   logic rd_valid_q;
   logic [5:0] rd_seg_q;
   logic [N_SEG-1:0] shadow_q;
   logic [N_SEG-1:0] disp_q;
   logic [3:0] applied_com_q;
   logic b_re;
   logic [RAM_AW-1:0] b_raddr;
   logic duty_eighth;
   logic dots_lit;
   logic dots_blank;
   logic [N_SEG-1:0] seg_d;
   logic [N_COM-1:0] com_d;

   assign duty_eighth = ctrl_q[DUTY_SELECT_BIT];
   assign dots_lit = ctrl_q[ALL_DOTS_LIT_BIT];
   assign dots_blank = ctrl_q[ALL_DOTS_BLANK_BIT];

   // ****************************************
   // ahb-lite address and data phase
   // ****************************************
   // a transfer is taken only with htrans nonseq or seq
   assign accept = i_hsel & i_hready & i_htrans[1];

   // address phase capture; hsize ignored, whole words only
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dph_valid_q <= 1'b0;
         dph_write_q <= 1'b0;
         dph_idx_q <= '0;
      end else if (i_hready) begin
         dph_valid_q <= accept;
         dph_write_q <= i_hwrite;
         dph_idx_q <= i_haddr[HADDR_W-1:2];
      end
   end

   // reads take one wait state so a write just before is seen
   assign rd_issue = dph_valid_q & ~dph_write_q & ~rd_done_q;
   assign wr_commit = dph_valid_q & dph_write_q;
   assign o_hreadyout = ~rd_issue;
   assign o_hresp = 1'b0;

   // wait-state tracker
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_done_q <= 1'b0;
      end else begin
         rd_done_q <= rd_issue;
      end
   end

   // display memory decode: bank from index bit 7 [RQ4]
   assign dph_is_disp = (dph_idx_q[11:8] == DISP_IDX_HI) &&
                        (dph_idx_q[6:0] <= DISP_LAST_OFS);
   assign dph_ram_addr = {dph_idx_q[7], dph_idx_q[6:0]};

   // ****************************************
   // control registers
   // ****************************************
   // display control: duty, lit, blank, heavy load [RQ7] [RQ8] [RQ9]
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q <= DISPLAY_CONTROL_RESET; // [RQ13]
      end else if (wr_commit &&
                   dph_idx_q == LCD_DISPLAY_CONTROL_IDX) begin
         ctrl_q <= i_hwdata[3:0];
      end
   end

   // contrast code; left to software after reset [RQ10] [RQ11]
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         contrast_q <= CONTRAST_RESET;
      end else if (wr_commit &&
                   dph_idx_q == LCD_CONTRAST_LEVEL_IDX) begin
         contrast_q <= i_hwdata[3:0];
      end
   end

   // drive voltage enable, bits 3..1 read as zero [RQ12]
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dve_q <= DRIVE_VOLTAGE_RESET;
      end else if (wr_commit &&
                   dph_idx_q == LCD_VOLTAGE_ENABLE_IDX) begin
         dve_q <= i_hwdata[DRIVE_VOLTAGE_ENABLE_BIT];
      end
   end

   // ****************************************
   // read data
   // ****************************************
   // register read mux; unmapped reads give zero
   always_comb begin
      rd_mux = '0;
      case (dph_idx_q)
         LCD_DISPLAY_CONTROL_IDX: begin
            rd_mux[3:0] = ctrl_q; // [RQ7]
         end
         LCD_CONTRAST_LEVEL_IDX: begin
            rd_mux[3:0] = contrast_q; // [RQ10]
         end
         LCD_VOLTAGE_ENABLE_IDX: begin
            rd_mux[DRIVE_VOLTAGE_ENABLE_BIT] = dve_q;
         end
         LCD_SCAN_STATUS_IDX: begin
            rd_mux[3:0] = applied_com_q;
            rd_mux[STATUS_BUSY_BIT] = (state_q != SC_IDLE);
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   // read data held until the next read
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         reg_rdata_q <= '0;
         sel_mem_q <= 1'b0;
      end else if (rd_issue) begin
         reg_rdata_q <= rd_mux;
         sel_mem_q <= dph_is_disp;
      end
   end

   // memory data comes straight from the ram output register
   assign o_hrdata = sel_mem_q ? {28'h0000000, a_rdata} : reg_rdata_q;

   // ****************************************
   // display memory
   // ****************************************
   // not cleared at reset; software must fill it [RQ6]
   ldm_disp_ram #(
      .AW(RAM_AW),
      .DW(NIB_W)
   ) u_ram (
      .i_ref_clk(i_ref_clk),
      .i_a_we(wr_commit & dph_is_disp),
      .i_a_waddr(dph_ram_addr),
      .i_a_wdata(i_hwdata[NIB_W-1:0]),
      .i_a_re(rd_issue & dph_is_disp),
      .i_a_raddr(dph_ram_addr),
      .o_a_rdata(a_rdata),
      .i_b_re(b_re),
      .i_b_raddr(b_raddr),
      .o_b_rdata(b_rdata)
   );

   // ****************************************
   // frame timing
   // ****************************************
   ldm_scan_timer #(
      .DIV_W(FRAME_DIV_W)
   ) u_tmr (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_low_osc(i_low_osc),
      .i_duty_eighth(duty_eighth),
      .o_step(step),
      .o_com_idx(tmr_com_idx)
   );

   // fetch starts one cycle after a step, once after reset too
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         start_q <= 1'b1;
      end else begin
         start_q <= step;
      end
   end

   // ****************************************
   // segment fetch for the new common
   // ****************************************
   // nibble at {bank, seg, half} holds four commons of one segment
   assign b_re = (state_q == SC_READ);
   assign b_raddr = {fetch_com_q[3], seg_cnt_q, fetch_com_q[2]}; // [RQ4]

   // fetch sequencer: 40 reads, drain, then apply
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= SC_IDLE;
         fetch_com_q <= '0;
         seg_cnt_q <= '0;
      end else begin
         case (state_q)
            SC_IDLE: begin
               if (start_q) begin
                  fetch_com_q <= tmr_com_idx;
                  seg_cnt_q <= '0;
                  state_q <= SC_READ;
               end
            end
            SC_READ: begin
               if (seg_cnt_q == 6'(N_SEG - 1)) begin
                  state_q <= SC_DRAIN;
               end else begin
                  seg_cnt_q <= seg_cnt_q + 1'b1;
               end
            end
            SC_DRAIN: begin
               state_q <= SC_APPLY;
            end
            SC_APPLY: begin
               state_q <= SC_IDLE;
            end
            default: begin
               state_q <= SC_IDLE;
            end
         endcase
      end
   end

   // tag ram output with the segment it belongs to
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_valid_q <= 1'b0;
         rd_seg_q <= '0;
      end else begin
         rd_valid_q <= b_re;
         rd_seg_q <= seg_cnt_q;
      end
   end

   // gather one bit per segment into the shadow row
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shadow_q <= '0;
      end else if (rd_valid_q) begin
         shadow_q[rd_seg_q] <= b_rdata[fetch_com_q[1:0]];
      end
   end

   // swap the whole row at once so no segment tears mid-step
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         disp_q <= '0;
         applied_com_q <= '0;
      end else if (state_q == SC_APPLY) begin
         disp_q <= shadow_q;
         applied_com_q <= fetch_com_q;
      end
   end

   // ****************************************
   // drive outputs
   // ****************************************
   // per-segment drive: off, lit, blank, then memory data
   for (genvar s = 0; s < N_SEG; s++) begin : g_seg
      always_comb begin
         if (!dve_q) begin
            seg_d[s] = 1'b0; // [RQ12]
         end else if (dots_lit) begin
            seg_d[s] = 1'b1; // [RQ8]
         end else if (dots_blank) begin
            seg_d[s] = 1'b0; // [RQ9]
         end else begin
            seg_d[s] = disp_q[s]; // [RQ5]
         end
      end
   end

   // one common active; upper eight idle at 1/8 duty
   for (genvar c = 0; c < N_COM; c++) begin : g_com
      always_comb begin
         com_d[c] = dve_q && (applied_com_q == 4'(c)) && // [RQ1]
                    (c < NUM_COM_EIGHTH || !duty_eighth); // [RQ3] [RQ2]
      end
   end

   // panel drive registers
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_segment_lines <= '0;
         o_common_lines <= '0;
      end else begin
         o_segment_lines <= seg_d;
         o_common_lines <= com_d;
      end
   end

   // analog controls; external supply ignores contrast [RQ14]
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_contrast_code <= CONTRAST_RESET;
         o_voltage_circuit_on <= 1'b0;
         o_heavy_load_protect <= 1'b0;
      end else begin
         o_contrast_code <= i_ext_lcd_power ? 4'h0 : contrast_q;
         o_voltage_circuit_on <= dve_q & ~i_ext_lcd_power; // [RQ12]
         o_heavy_load_protect <= ctrl_q[HEAVY_LOAD_PROTECT_BIT]; // [RQ13]
      end
   end
endmodule

// File: hw/ldm_scan_timer.sv
// ldm_scan_timer: frame divider and common-line stepping
`timescale 1ns/1ps
module ldm_scan_timer
   import ldm_pkg::*;
#(
   parameter int DIV_W = FRAME_DIV_W
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_low_osc,
   input wire logic i_duty_eighth,
   output logic o_step,
   output logic [3:0] o_com_idx
);
   logic osc_q;
   logic [DIV_W-1:0] cnt_q;
   logic tick;

   if (DIV_W != FRAME_DIV_W) begin : g_chk
      $error("ldm_scan_timer: divider width must match frame divide");
   end

   // rising edge of the low-frequency oscillator
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         osc_q <= 1'b0;
      end else begin
         osc_q <= i_low_osc;
      end
   end
   assign tick = i_low_osc & ~osc_q;

   // one wrap of the counter is one frame under either duty [RQ15]
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // equal slices per common: 64 ticks at 1/16, 128 at 1/8 [RQ15]
   assign o_step = tick & (i_duty_eighth ? (&cnt_q[6:0]) : (&cnt_q[5:0]));
   assign o_com_idx = i_duty_eighth ? {1'b0, cnt_q[9:7]} : cnt_q[9:6];
endmodule

// File: tb/ldm_lcd_driver_assertions.sv
// checker: port-level assertions for the lcd driver
`timescale 1ns/1ps
module ldm_lcd_driver_checker
   import ldm_pkg::*;
#(
   parameter int N_COM = NUM_COM,
   parameter int N_SEG = NUM_SEG
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_hsel,
   input wire logic [HADDR_W-1:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic i_ext_lcd_power,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic [N_COM-1:0] o_common_lines,
   input wire logic [N_SEG-1:0] o_segment_lines,
   input wire logic [3:0] o_contrast_code,
   input wire logic o_voltage_circuit_on,
   input wire logic o_heavy_load_protect
);
   // ****************************************
   // shadow of the writable fields
   // ****************************************
   logic take;
   logic wp_q;
   logic en_q;
   logic [11:0] ix_q;
   logic [3:0] ctl_q;
   logic [3:0] con_q;
   assign take = i_hsel & i_hready & i_htrans[1];
   // address phase capture; writes land at the next edge
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wp_q <= 1'b0;
         ix_q <= 12'h000;
      end else begin
         wp_q <= take & i_hwrite;
         ix_q <= i_haddr[13:2];
      end
   end
   // mirrors track the registers without reading them back
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl_q <= DISPLAY_CONTROL_RESET;
         con_q <= CONTRAST_RESET;
         en_q <= DRIVE_VOLTAGE_RESET;
      end else if (wp_q) begin
         if (ix_q == LCD_DISPLAY_CONTROL_IDX) ctl_q <= i_hwdata[3:0];
         if (ix_q == LCD_CONTRAST_LEVEL_IDX) con_q <= i_hwdata[3:0];
         if (ix_q == LCD_VOLTAGE_ENABLE_IDX) en_q <= i_hwdata[0];
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_rd_wait;
      !o_hreadyout ##1 o_hreadyout;
   endsequence
   a_read_wait: assert property (take && !i_hwrite |=> s_rd_wait)
      else $error("read data phase not one wait state");
   a_write_nowait: assert property (wp_q |-> o_hreadyout)
      else $error("write data phase stalled");
   a_resp_okay: assert property (o_hresp == 1'b0)
      else $error("response not okay");
   a_one_common: assert property ($onehot0(o_common_lines))
      else $error("more than one common driven");
   a_eighth_low: assert property ($rose(|o_common_lines[15:8]) |->
      !($past(ctl_q[1], 50) && ctl_q[1]))
      else $error("upper common scanned at eighth duty");
   a_lit_all: assert property ($past(ctl_q[2]) && ctl_q[2] &&
      |o_common_lines |-> &o_segment_lines)
      else $error("all-lit left a dot dark");
   a_blank_dark: assert property ($past(ctl_q[3:2]) == 2'b10 &&
      ctl_q[3:2] == 2'b10 |-> o_segment_lines == '0)
      else $error("blank left a dot lit");
   a_off_ground: assert property (!$past(en_q) && !en_q |->
      o_common_lines == '0 && o_segment_lines == '0)
      else $error("drive not grounded while disabled");
   a_hlp_copy: assert property ($past(i_rst_n) |->
      o_heavy_load_protect == $past(ctl_q[0]))
      else $error("heavy load output differs from field");
   a_contrast_out: assert property ($past(i_rst_n) && $past(en_q) |->
      o_contrast_code == ($past(i_ext_lcd_power) ? 4'h0 : $past(con_q)))
      else $error("contrast output wrong");
   a_volt_on: assert property ($past(i_rst_n) |-> o_voltage_circuit_on ==
      ($past(en_q) && !$past(i_ext_lcd_power)))
      else $error("voltage circuit state wrong");
endmodule

bind ldm_lcd_driver ldm_lcd_driver_checker #(.N_COM(N_COM), .N_SEG(N_SEG))
   u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
   .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
   .i_hwdata(i_hwdata), .i_hready(i_hready),
   .i_ext_lcd_power(i_ext_lcd_power), .o_hreadyout(o_hreadyout),
   .o_hresp(o_hresp), .o_common_lines(o_common_lines),
   .o_segment_lines(o_segment_lines), .o_contrast_code(o_contrast_code),
   .o_voltage_circuit_on(o_voltage_circuit_on),
   .o_heavy_load_protect(o_heavy_load_protect));

// File: tb/ldm_panel_model.sv
// ldm_panel_model: lcd panel that records each row it is shown
`timescale 1ns/1ps
module ldm_panel_model (
   input wire logic i_ref_clk,
   input wire logic i_clear,
   input wire logic [15:0] i_common_lines,
   input wire logic [39:0] i_segment_lines,
   output logic [15:0] o_seen
);
   logic [39:0] img [16];
   int t_on [16];
   int cyc = 0;
   logic [15:0] prev_q = 16'h0000;
   // a row is what the segments show while its common is driven
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      prev_q <= i_common_lines;
      if (i_clear) o_seen <= 16'h0000;
      for (int c = 0; c < 16; c++) begin
         if (i_common_lines[c]) begin
            img[c] <= i_segment_lines;
            o_seen[c] <= 1'b1;
            if (!prev_q[c]) t_on[c] <= cyc;
         end
      end
   end
endmodule

// File: tb/tb_lcd_dot_matrix_driver.sv
// tb_lcd_dot_matrix_driver: self-checking bench for the lcd driver
`timescale 1ns/1ps
module tb_lcd_dot_matrix_driver
   import ldm_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic osc = 1'b0;
   logic ext = 1'b0;
   logic clr = 1'b0;
   logic [13:0] haddr = 14'h0000;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rdat;
   wire hready;
   wire hresp;
   wire von;
   wire hlp;
   wire [3:0] con;
   wire [31:0] hrdata;
   wire [15:0] com;
   wire [39:0] seg;
   int bad_count = 0;
   int n_compared = 0;
   // oscillator runs fast so a frame stays short in simulation
   always #2 clk = ~clk;
   always @(posedge clk) osc <= ~osc;
   ldm_lcd_driver DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
      .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
      .i_low_osc(osc), .i_ext_lcd_power(ext), .o_common_lines(com),
      .o_segment_lines(seg), .o_contrast_code(con),
      .o_voltage_circuit_on(von), .o_heavy_load_protect(hlp));
   ldm_panel_model PANEL (.i_ref_clk(clk), .i_clear(clr),
      .i_common_lines(com), .i_segment_lines(seg), .o_seen());
   // ****************************************
   // helpers
   // ****************************************
   task automatic test_done();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e,
      input logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // single word transfer; hready looked at where settled, no cycle limit
   // so a stuck slave is caught by the watchdog, not skipped silently
   task automatic xfer(input logic w, input logic [11:0] ix,
      input logic [3:0] wd);
      hsel <= 1'b1;
      haddr <= {ix, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      do @(negedge clk); while (hready !== 1'b1);
      @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {28'h0, wd};
      do @(negedge clk); while (hready !== 1'b1);
      rdat = hrdata;
      @(posedge clk);
   endtask
   task automatic rd_chk(input string nm, input logic [11:0] ix,
      input logic [3:0] e);
      xfer(1'b0, ix, 4'h0);
      chk(nm, {60'h0, e}, rdat);
   endtask
   function automatic logic [3:0] pat(input int b, input int a);
      return 4'(a * 7 + b * 5);
   endfunction
   // bank by common half, nibble half by common quarter, bit by common
   function automatic logic [39:0] exp_row(input int c);
      logic [39:0] r;
      logic [3:0] v;
      for (int s = 0; s < 40; s++) begin
         v = pat(c / 8, 2 * s + (c / 4) % 2);
         r[s] = v[c % 4];
      end
      return r;
   endfunction
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      rd_chk("control", LCD_DISPLAY_CONTROL_IDX, 4'h8);
      rd_chk("voltage", LCD_VOLTAGE_ENABLE_IDX, 4'h1);
      xfer(1'b1, 12'h123, 4'h5);
      rd_chk("unmapped", 12'h123, 4'h0);
      chk("heavy load", 64'h0, hlp);
   endtask
   task automatic t_regs();
      for (int v = 0; v < 16; v++) begin
         xfer(1'b1, LCD_CONTRAST_LEVEL_IDX, 4'(v));
         rd_chk("contrast", LCD_CONTRAST_LEVEL_IDX, 4'(v));
         chk("contrast out", 64'(v), con);
         xfer(1'b1, LCD_DISPLAY_CONTROL_IDX, 4'(v));
         rd_chk("control", LCD_DISPLAY_CONTROL_IDX, 4'(v));
         chk("heavy load", 64'(v % 2), hlp);
      end
      xfer(1'b1, LCD_VOLTAGE_ENABLE_IDX, 4'hf);
      rd_chk("voltage", LCD_VOLTAGE_ENABLE_IDX, 4'h1);
      xfer(1'b1, LCD_CONTRAST_LEVEL_IDX, 4'h7);
   endtask
   task automatic t_scan(input logic d);
      logic [15:0] m;
      m = d ? 16'h00ff : 16'hffff;
      xfer(1'b1, LCD_DISPLAY_CONTROL_IDX, {2'b00, d, 1'b0});
      repeat (2100) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (5000) @(posedge clk);
      chk("commons used", m, PANEL.o_seen);
      @(posedge com[3]);
      chk("row pitch", 2 * 1024 / (d ? 8 : 16),
         PANEL.t_on[2] - PANEL.t_on[1]);
      for (int c = 0; c < 16; c++) begin
         if (m[c]) chk("row", exp_row(c), PANEL.img[c]);
      end
      // common 3 just applied, next step is far off: idle, index 3
      rd_chk("scan status", LCD_SCAN_STATUS_IDX, 4'h3);
   endtask
   task automatic t_override();
      xfer(1'b1, LCD_DISPLAY_CONTROL_IDX, 4'h4);
      repeat (2) @(posedge clk);
      chk("all lit", {40{1'b1}}, seg);
      xfer(1'b1, LCD_DISPLAY_CONTROL_IDX, 4'hc);
      repeat (2) @(posedge clk);
      chk("lit over blank", {40{1'b1}}, seg);
      xfer(1'b1, LCD_DISPLAY_CONTROL_IDX, 4'h8);
      repeat (200) @(posedge clk);
      chk("all blank", 64'h0, seg);
      rd_chk("memory kept", 12'he81, pat(1, 1));
   endtask
   task automatic t_power();
      xfer(1'b1, LCD_VOLTAGE_ENABLE_IDX, 4'h0);
      repeat (2) @(posedge clk);
      chk("drive off", 64'h0, {com, seg, von});
      xfer(1'b1, LCD_VOLTAGE_ENABLE_IDX, 4'h1);
      ext <= 1'b1;
      repeat (3) @(posedge clk);
      chk("external", 64'h0, {von, con});
      ext <= 1'b0;
      repeat (3) @(posedge clk);
      chk("internal", 64'h17, {von, con});
   endtask
   // main sequence; memory is filled after the register tests, before the scan checks
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_regs();
      for (int b = 0; b < 2; b++) begin
         for (int a = 0; a < 80; a++) begin
            xfer(1'b1, 12'(12'he00 + 128 * b + a), pat(b, a));
         end
      end
      t_scan(1'b0);
      t_scan(1'b1);
      t_override();
      t_power();
      test_done();
   end
   // the run needs about 20000 cycles; three times that means a hang
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      test_done();
   end
endmodule
